//--- ccr_pkg.sv
// ccr_pkg.sv : constants shared by the condition and control register block
// assumes a 32-bit ahb-lite bus with the block as its only slave
package ccr_pkg;

  // ==========================================================================
  // register indices (byte address = index * 4)
  // ==========================================================================
  localparam logic [7:0] IDX_TIMER_MODE   = 8'hF1;  // timer mode control
  localparam logic [7:0] IDX_COUNTER0     = 8'hF4;  // counter/timer0
  localparam logic [7:0] IDX_PRIORITY     = 8'hF9;  // interrupt priority, write only
  localparam logic [7:0] IDX_PENDING      = 8'hFA;  // pending interrupt requests
  localparam logic [7:0] IDX_MASK         = 8'hFB;  // interrupt mask
  localparam logic [7:0] IDX_FLAGS        = 8'hFC;  // condition flags
  localparam logic [7:0] IDX_WINDOW_BASE  = 8'hFD;  // working-register window base
  localparam logic [7:0] IDX_GENERAL      = 8'hFE;  // general purpose
  localparam logic [7:0] IDX_STACK_LOW    = 8'hFF;  // stack pointer low byte
  localparam logic [7:0] IDX_EVT_STATUS   = 8'hE0;  // sticky event status
  localparam logic [7:0] IDX_EVT_MASK     = 8'hE1;  // event interrupt mask

  // ==========================================================================
  // address decode layout
  // ==========================================================================
  localparam int IDX_LSB = 2;   // word aligned registers
  localparam int IDX_MSB = 9;   // eight index bits
  localparam int ADR_MSB = 31;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] RST_BYTE = 8'h00;  // every control register clears to this

  // ==========================================================================
  // flag register layout
  // ==========================================================================
  localparam int FLAG_CARRY    = 7;
  localparam int FLAG_ZERO     = 6;
  localparam int FLAG_SIGN     = 5;
  localparam int FLAG_OVERFLOW = 4;
  localparam int FLAG_DECIMAL  = 3;
  localparam int FLAG_HALF     = 2;
  localparam int MASK_GLOBAL   = 7;   // global interrupt enable in the mask
  localparam int NUM_REQ       = 6;   // interrupt request lines

  // ==========================================================================
  // event status layout
  // ==========================================================================
  localparam int EVT_REQ  = 0;  // an interrupt request arrived
  localparam int EVT_FLAG = 1;  // the core updated the flags
  localparam int NUM_EVT  = 2;

  // ==========================================================================
  // condition codes
  // ==========================================================================
  localparam logic [3:0] CC_NEVER             = 4'h0;
  localparam logic [3:0] CC_SIGNED_BELOW      = 4'h1;
  localparam logic [3:0] CC_SIGNED_AT_MOST    = 4'h2;
  localparam logic [3:0] CC_UNSIGNED_AT_MOST  = 4'h3;
  localparam logic [3:0] CC_ARITH_WRAP_SET    = 4'h4;
  localparam logic [3:0] CC_SIGN_SET_TEST     = 4'h5;
  localparam logic [3:0] CC_ZERO_SET          = 4'h6;
  localparam logic [3:0] CC_UNSIGNED_BELOW    = 4'h7;
  localparam logic [3:0] CC_ALWAYS            = 4'h8;
  localparam logic [3:0] CC_SIGNED_AT_LEAST   = 4'h9;
  localparam logic [3:0] CC_SIGNED_ABOVE      = 4'hA;
  localparam logic [3:0] CC_UNSIGNED_ABOVE    = 4'hB;
  localparam logic [3:0] CC_ARITH_WRAP_CLEAR  = 4'hC;
  localparam logic [3:0] CC_SIGN_CLEAR_TEST   = 4'hD;
  localparam logic [3:0] CC_ZERO_CLEAR        = 4'hE;
  localparam logic [3:0] CC_UNSIGNED_AT_LEAST = 4'hF;

  // ==========================================================================
  // bus encodings
  // ==========================================================================
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

//--- ccr_regs.sv
// ccr_regs.sv : condition-code evaluator and control register map of the core
// assumes one hclk domain, an ahb-lite master, and a core that drives flags,
// request pulses and condition codes synchronous to hclk
`timescale 1ns/1ps
`default_nettype none

// How it works
// - code 0000 never true, 1000 always true
// - 0111 true on carry, 1111 on no carry
// - 1011 needs carry and zero clear; 0011 either set
// - 1001 when sign equals overflow; 0001 otherwise
// - 1010 when zero and sign-xor-overflow both clear; 0010 either set
// - six flags kept in the flag register
// - flag register read and written by software
// - window base pointer read/write register
// - stack pointer low byte read/write register
// - interrupt mask read/write, bit 7 global enable
// - priority register write only, reads hide it
// - pending requests read/write by software
// - timer mode read/write, cleared on reset
// - counter/timer0 read/write register
module ccr_regs
  import ccr_pkg::*;
(
  input  wire logic        hclk,                 // core clock
  input  wire logic        hresetn,              // async reset, active low
  input  wire logic        hsel,                 // slave select
  input  wire logic [31:0] haddr,                // byte address
  input  wire logic [1:0]  htrans,               // transfer type
  input  wire logic        hwrite,               // write when high
  input  wire logic [2:0]  hsize,                // word only
  input  wire logic [31:0] hwdata,               // write data
  input  wire logic        hready,               // bus ready
  output logic             hreadyout,            // never inserts wait states
  output logic             hresp,                // always okay
  output logic [31:0]      hrdata,               // read data
  input  wire logic [3:0]  cond_code,            // condition field under test
  output logic             cond_true,            // registered test result
  input  wire logic        flag_we,              // core writes the flags
  input  wire logic [7:0]  flag_in,              // new flag value from core
  input  wire logic [NUM_REQ-1:0] int_req,       // request pulses
  output logic [7:0]       timer_mode,           // timer mode control
  output logic [7:0]       counter_timer0,       // counter/timer0 value
  output logic [7:0]       interrupt_priority,   // priority setting
  output logic [7:0]       interrupt_mask_reg,   // interrupt mask
  output logic [7:0]       window_base_pointer,  // working window base
  output logic [7:0]       stack_top_low,        // stack pointer low byte
  output logic             int_active,           // enabled request pending
  output logic             irq                   // event interrupt, level
);

  // ==========================================================================
  // state
  // ==========================================================================
  // every flop of the block, one struct
  // so none can be missed by reset
  typedef struct packed {
    logic               dp_valid;   // a data phase is open
    logic               dp_write;   // it is a write
    logic               dp_mapped;  // address hit the map area
    logic [7:0]         dp_idx;     // register index
    logic [7:0]         tmode;      // timer mode
    logic [7:0]         cnt0;       // counter/timer0
    logic [7:0]         prio;       // priority
    logic [7:0]         pend;       // pending requests
    logic [7:0]         mask;       // interrupt mask
    logic [7:0]         flags;      // condition flags
    logic [7:0]         wbase;      // window base
    logic [7:0]         general_purpose;        // general purpose
    logic [7:0]         splo;       // stack low
    logic [NUM_EVT-1:0] evt_st;     // sticky event status
    logic [NUM_EVT-1:0] evt_mk;     // event mask
    logic [7:0]         rdata;      // read data for the data phase
    logic               cond;       // condition result
  } ccr_state_s;

  // registered copy and its next value
  ccr_state_s st_q;  // registered state
  ccr_state_s st_d;  // next state

  // ==========================================================================
  // condition evaluation
  // ==========================================================================
  // test one condition field against the flag register
  // flags: c 7, z 6, s 5, v 4, d 3, h 2
  // a code with bit 3 set is the inverse
  // of the same code with bit 3 clear
  function automatic logic ccr_eval(input logic [3:0] cc, input logic [7:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    logic r;
    c = f[FLAG_CARRY];
    z = f[FLAG_ZERO];
    s = f[FLAG_SIGN];
    v = f[FLAG_OVERFLOW];
    // r carries the result of the test
    case (cc)
      CC_NEVER:             r = 1'b0;
      CC_ALWAYS:            r = 1'b1;
      CC_UNSIGNED_BELOW:    r = c;
      CC_UNSIGNED_AT_LEAST: r = !c;
      CC_UNSIGNED_ABOVE:    r = !c && !z;
      CC_UNSIGNED_AT_MOST:  r = c || z;
      CC_SIGNED_AT_LEAST:   r = !(s ^ v);
      CC_SIGNED_BELOW:      r = s ^ v;
      CC_SIGNED_ABOVE:      r = !(z || (s ^ v));
      CC_SIGNED_AT_MOST:    r = z || (s ^ v);
      CC_ZERO_SET:          r = z;
      CC_ZERO_CLEAR:        r = !z;
      CC_SIGN_CLEAR_TEST:   r = !s;
      CC_SIGN_SET_TEST:     r = s;
      CC_ARITH_WRAP_SET:    r = v;
      default:              r = !v;                // overflow clear
    endcase
    return r;
  endfunction

  // ==========================================================================
  // next state
  // ==========================================================================
  // decode, register updates, event tracking and read data in one pass
  // address phase taken on hsel, hready, nonseq
  // data phase is the next cycle, no waits
  // hsize is ignored, words only
  // writes land at the end of the data phase
  // read word built from the next state
  // so a read after a write sees the new value
  // byte address is index times four:
  //   0x3C4 timer mode, 0x3D0 counter/timer0
  //   0x3E4 priority, 0x3E8 pending
  //   0x3EC mask, 0x3F0 flags
  //   0x3F4 window base, 0x3F8 general
  //   0x3FC stack low, 0x380 and 0x384 events
  //   bits 31:10 set means unmapped
  always_comb begin
    logic        take;
    logic        wr;
    logic [7:0]  wb;
    logic [NUM_EVT-1:0] evt_set;
    st_d    = st_q;
    // take marks an address phase this cycle
    take    = hsel && hready && (htrans == HTRANS_NONSEQ);
    wr      = st_q.dp_valid && st_q.dp_write && st_q.dp_mapped;
    wb      = hwdata[7:0];
    evt_set = '0;
    // writes land at the end of their data phase
    if (wr) begin
      if (st_q.dp_idx == IDX_TIMER_MODE) begin
        st_d.tmode = wb;
      end else if (st_q.dp_idx == IDX_COUNTER0) begin
        st_d.cnt0 = wb;
      end else if (st_q.dp_idx == IDX_PRIORITY) begin
        st_d.prio = wb;
      end else if (st_q.dp_idx == IDX_PENDING) begin
        st_d.pend = wb;
      end else if (st_q.dp_idx == IDX_MASK) begin
        st_d.mask = wb;
      end else if (st_q.dp_idx == IDX_FLAGS) begin
        st_d.flags = wb;
      end else if (st_q.dp_idx == IDX_WINDOW_BASE) begin
        st_d.wbase = wb;
      end else if (st_q.dp_idx == IDX_GENERAL) begin
        st_d.general_purpose = wb;
      end else if (st_q.dp_idx == IDX_STACK_LOW) begin
        st_d.splo = wb;
      end else if (st_q.dp_idx == IDX_EVT_STATUS) begin
        st_d.evt_st = st_q.evt_st & ~wb[NUM_EVT-1:0];  // write one to clear
      end else if (st_q.dp_idx == IDX_EVT_MASK) begin
        st_d.evt_mk = wb[NUM_EVT-1:0];
      end
    end
    // core flag update overrides a software write in the same cycle
    // event bit tells core updates apart
    if (flag_we) begin
      st_d.flags = flag_in;
      evt_set[EVT_FLAG] = 1'b1;
    end
    // incoming requests win over a software clear of the pending bit
    // each line sets its own pending bit
    if (|int_req) begin
      st_d.pend[NUM_REQ-1:0] = st_d.pend[NUM_REQ-1:0] | int_req;
      evt_set[EVT_REQ] = 1'b1;
    end
    // sticky status collects this cycle's events
    st_d.evt_st = st_d.evt_st | evt_set;           // set wins over clear
    // capture the address phase
    // stored every cycle; dp_valid says
    // whether a real transfer owns them
    st_d.dp_valid  = take;
    st_d.dp_write  = hwrite;
    st_d.dp_idx    = haddr[IDX_MSB:IDX_LSB];
    st_d.dp_mapped = (haddr[ADR_MSB:IDX_MSB+1] == '0);
    // read data comes from the updated values so a write then read is seen
    // no read in flight shows zero
    st_d.rdata = RST_BYTE;
    // read decode, priority left out on purpose
    if (take && !hwrite && st_d.dp_mapped) begin
      if (st_d.dp_idx == IDX_TIMER_MODE) begin
        st_d.rdata = st_d.tmode;
      end else if (st_d.dp_idx == IDX_COUNTER0) begin
        st_d.rdata = st_d.cnt0;
      end else if (st_d.dp_idx == IDX_PENDING) begin
        st_d.rdata = st_d.pend;
      end else if (st_d.dp_idx == IDX_MASK) begin
        st_d.rdata = st_d.mask;
      end else if (st_d.dp_idx == IDX_FLAGS) begin
        st_d.rdata = st_d.flags;
      end else if (st_d.dp_idx == IDX_WINDOW_BASE) begin
        st_d.rdata = st_d.wbase;
      end else if (st_d.dp_idx == IDX_GENERAL) begin
        st_d.rdata = st_d.general_purpose;
      end else if (st_d.dp_idx == IDX_STACK_LOW) begin
        st_d.rdata = st_d.splo;
      end else if (st_d.dp_idx == IDX_EVT_STATUS) begin
        st_d.rdata = {{(8-NUM_EVT){1'b0}}, st_d.evt_st};
      end else if (st_d.dp_idx == IDX_EVT_MASK) begin
        st_d.rdata = {{(8-NUM_EVT){1'b0}}, st_d.evt_mk};
      end
      // priority and unmapped indices read as zero
    end
    // condition test on the current flags
    // so cond_true lags cond_code by one
    st_d.cond = ccr_eval(cond_code, st_q.flags);
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  // every field clears to a constant
  // constants only in the reset branch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;                                  // timer mode 00
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  // never stalls, never reports an error
  // register outputs come from flops
  assign hreadyout           = 1'b1;
  assign hresp               = HRESP_OKAY;
  assign hrdata              = {24'h000000, st_q.rdata};
  assign cond_true           = st_q.cond;
  assign timer_mode          = st_q.tmode;
  assign counter_timer0      = st_q.cnt0;
  assign interrupt_priority  = st_q.prio;
  assign interrupt_mask_reg  = st_q.mask;
  assign window_base_pointer = st_q.wbase;
  assign stack_top_low       = st_q.splo;
  // global enable gates every masked pending request
  assign int_active = st_q.mask[MASK_GLOBAL] &&
                      |(st_q.pend[NUM_REQ-1:0] & st_q.mask[NUM_REQ-1:0]);
  // level, while a masked-in event stands
  assign irq        = |(st_q.evt_st & st_q.evt_mk);

  // ==========================================================================
  // assertions
  // ==========================================================================
  // each check looks one cycle after
  // the inputs that cause it; reset
  // disables all but the reset check

  // ==========================================================================
  // assertion helpers
  // ==========================================================================
  // helper: a write data phase to the window base
  logic wr_base_seen;
  assign wr_base_seen = st_q.dp_valid && st_q.dp_write && st_q.dp_mapped &&
                        st_q.dp_idx == IDX_WINDOW_BASE;

  // never and always ignore the flags
  a_cc_never_always: assert property (@(posedge hclk) disable iff (!hresetn)
    (cond_code == CC_NEVER || cond_code == CC_ALWAYS) |=>
      cond_true == ($past(cond_code) == CC_ALWAYS))
    else $error("never/always condition wrong");

  // carry set and carry clear tests
  a_cc_carry_pair: assert property (@(posedge hclk) disable iff (!hresetn)
    (cond_code == CC_UNSIGNED_BELOW || cond_code == CC_UNSIGNED_AT_LEAST) |=>
      cond_true == ($past(st_q.flags[FLAG_CARRY]) ^
                    ($past(cond_code) == CC_UNSIGNED_AT_LEAST)))
    else $error("carry condition wrong");

  // unsigned above needs c and z clear
  a_cc_unsigned_above: assert property (@(posedge hclk) disable iff (!hresetn)
    (cond_code == CC_UNSIGNED_ABOVE) |=>
      cond_true == !($past(st_q.flags[FLAG_CARRY]) || $past(st_q.flags[FLAG_ZERO])))
    else $error("unsigned above condition wrong");

  // signed below is sign xor overflow
  a_cc_signed_below: assert property (@(posedge hclk) disable iff (!hresetn)
    (cond_code == CC_SIGNED_BELOW) |=>
      cond_true == ($past(st_q.flags[FLAG_SIGN]) ^ $past(st_q.flags[FLAG_OVERFLOW])))
    else $error("signed below condition wrong");

  // signed above and at most are inverses
  a_cc_signed_above: assert property (@(posedge hclk) disable iff (!hresetn)
    (cond_code == CC_SIGNED_ABOVE || cond_code == CC_SIGNED_AT_MOST) |=>
      cond_true == (($past(st_q.flags[FLAG_ZERO]) ||
                     ($past(st_q.flags[FLAG_SIGN]) ^ $past(st_q.flags[FLAG_OVERFLOW]))) ^
                    ($past(cond_code) == CC_SIGNED_ABOVE)))
    else $error("signed above or at most wrong");

  // zero set follows the zero flag
  a_cc_zero_test: assert property (@(posedge hclk) disable iff (!hresetn)
    (cond_code == CC_ZERO_SET) |=> cond_true == $past(st_q.flags[FLAG_ZERO]))
    else $error("zero condition wrong");

  // a core flag write lands and is logged
  a_flag_update: assert property (@(posedge hclk) disable iff (!hresetn)
    flag_we |=> (st_q.flags == $past(flag_in)) && st_q.evt_st[EVT_FLAG])
    else $error("core flag update lost");

  // priority reads back as zero
  a_prio_hidden: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.dp_valid && !st_q.dp_write && st_q.dp_idx == IDX_PRIORITY) |-> hrdata == '0)
    else $error("priority register readable");

  // window base takes the written byte
  a_base_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_base_seen) |=> window_base_pointer == $past(hwdata[7:0]))
    else $error("window base write lost");

  // every request line sets its bit
  a_pending_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (|int_req) |=> ((st_q.pend[NUM_REQ-1:0] & $past(int_req)) == $past(int_req)) &&
      st_q.evt_st[EVT_REQ])
    else $error("request not latched");

  // timer mode is zero after reset
  a_timer_reset: assert property (@(posedge hclk)
    $rose(hresetn) |-> timer_mode == RST_BYTE)
    else $error("timer mode not cleared");

endmodule

`default_nettype wire

//--- ccr_regs_tb_top.sv
// ccr_regs_tb_top.sv : self-checking bench for the condition and control register block
// assumes ccr_pkg compiled first and ccr_regs as the single ahb-lite slave
`timescale 1ns/1ps
`default_nettype none

module ccr_regs_tb_top
  import ccr_pkg::*;
;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic        hclk;                 // 10 MHz bus clock
  logic        hresetn;              // async reset, active low
  logic        hsel;                 // slave select
  logic [31:0] haddr;                // byte address
  logic [1:0]  htrans;               // transfer type
  logic        hwrite;               // write strobe
  logic [2:0]  hsize;                // transfer size
  logic [31:0] hwdata;               // write data
  logic        hreadyout;            // slave ready, also the bus ready
  logic        hresp;                // response
  logic [31:0] hrdata;               // read data
  logic [3:0]  cond_code;            // condition under test
  logic        cond_true;            // registered result
  logic        flag_we;              // core flag write
  logic [7:0]  flag_in;              // core flag value
  logic [NUM_REQ-1:0] int_req;       // request pulses
  logic [7:0]  timer_mode;           // register mirrors
  logic [7:0]  counter_timer0;
  logic [7:0]  interrupt_priority;
  logic [7:0]  interrupt_mask_reg;
  logic [7:0]  window_base_pointer;
  logic [7:0]  stack_top_low;
  logic        int_active;           // enabled request pending
  logic        irq;                  // event interrupt
  int          fail_count;           // mismatches seen
  int          checks_done;          // comparisons made
  logic [31:0] rd;                   // last read word

  // one row of the register table: index, data written, word read back
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wdat;
    logic [7:0] rexp;
  } ccr_row_s;
  ccr_row_s rows [9] = '{
    '{8'hF1, 8'hA5, 8'hA5}, '{8'hF4, 8'h3C, 8'h3C}, '{8'hF9, 8'h5A, 8'h00},
    '{8'hFA, 8'h15, 8'h15}, '{8'hFB, 8'h81, 8'h81}, '{8'hFC, 8'hC3, 8'hC3},
    '{8'hFD, 8'h7E, 8'h7E}, '{8'hFE, 8'h99, 8'h99}, '{8'hFF, 8'hE7, 8'hE7}};

  // ==========================================================================
  // clock and design
  // ==========================================================================
  // free running clock, 100 ns period
  always #50 hclk = ~hclk;

  ccr_regs u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cond_code(cond_code),
    .cond_true(cond_true), .flag_we(flag_we), .flag_in(flag_in), .int_req(int_req),
    .timer_mode(timer_mode), .counter_timer0(counter_timer0),
    .interrupt_priority(interrupt_priority), .interrupt_mask_reg(interrupt_mask_reg),
    .window_base_pointer(window_base_pointer), .stack_top_low(stack_top_low),
    .int_active(int_active), .irq(irq));

  // ==========================================================================
  // tasks
  // ==========================================================================
  // word compare, unknowns never match
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one single ahb-lite transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
  endtask

  // register index to byte address
  function automatic logic [31:0] adr(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction

  // expected test result for a condition and flags c z s v
  function automatic logic cc_ref(input logic [3:0] cc, input logic [3:0] f);
    logic c, z, s, v;
    {c, z, s, v} = f;
    case (cc)
      4'h0: return 1'b0;
      4'h8: return 1'b1;
      4'h7: return c;
      4'hF: return !c;
      4'hB: return !c && !z;
      4'h3: return c || z;
      4'h9: return !(s ^ v);
      4'h1: return s ^ v;
      4'hA: return !(z || (s ^ v));
      4'h2: return z || (s ^ v);
      4'h6: return z;
      4'hE: return !z;
      4'hD: return !s;
      4'h5: return s;
      4'h4: return v;
      default: return !v;
    endcase
  endfunction

  // print counts and verdict, then stop
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // watchdog
  // ==========================================================================
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    print_verdict();
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 0; hwdata = 0; cond_code = 0; flag_we = 0; flag_in = 0; int_req = 0;
    fail_count = 0; checks_done = 0; rd = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // timer mode reset value, then table rows written and read back
    bus(1'b0, adr(IDX_TIMER_MODE), 32'h0);
    check("timer_mode reset", 32'h0, rd);
    foreach (rows[i]) begin
      bus(1'b1, adr(rows[i].idx), {24'h0, rows[i].wdat});
      bus(1'b0, adr(rows[i].idx), 32'h0);
      check("reg read", {24'h0, rows[i].rexp}, rd);
    end
    check("timer_mode out", 32'hA5, {24'h0, timer_mode});
    check("counter0 out", 32'h3C, {24'h0, counter_timer0});
    check("priority out", 32'h5A, {24'h0, interrupt_priority});
    check("window out", 32'h7E, {24'h0, window_base_pointer});
    check("stack out", 32'hE7, {24'h0, stack_top_low});
    check("mask out", 32'h81, {24'h0, interrupt_mask_reg});
    // unmapped address: read gives zero, write leaves timer mode alone
    bus(1'b1, 32'h0000_13C4, 32'hFF);
    bus(1'b0, 32'h0000_13C4, 32'h0);
    check("unmapped read", 32'h0, rd);
    check("timer_mode kept", 32'hA5, {24'h0, timer_mode});
    // global enable on with pending bit 0 unmasked, then off
    check("int_active on", 32'h1, {31'h0, int_active});
    bus(1'b1, adr(IDX_MASK), 32'h01);
    @(posedge hclk);
    check("int_active off", 32'h0, {31'h0, int_active});
    // clear pending, then a core request pulse sets it again
    bus(1'b1, adr(IDX_PENDING), 32'h0);
    int_req <= 6'h02;
    @(posedge hclk);
    int_req <= 6'h00;
    bus(1'b0, adr(IDX_PENDING), 32'h0);
    check("pending req", 32'h02, rd);
    // event status raised, masked in, cleared by writing one
    check("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, adr(IDX_EVT_MASK), 32'h01);
    @(posedge hclk);
    check("irq raised", 32'h1, {31'h0, irq});
    bus(1'b1, adr(IDX_EVT_STATUS), 32'h01);
    bus(1'b0, adr(IDX_EVT_STATUS), 32'h0);
    check("status cleared", 32'h0, rd & 32'h1);
    check("irq cleared", 32'h0, {31'h0, irq});
    // every condition against every carry zero sign overflow pattern
    for (int f = 0; f < 16; f++) begin
      flag_we <= 1'b1;
      flag_in <= {f[3:0], 4'hC};
      @(posedge hclk);
      flag_we <= 1'b0;
      for (int c = 0; c < 16; c++) begin
        cond_code <= c[3:0];
        @(posedge hclk);
        #1;
        check("cond_true", {31'h0, cc_ref(c[3:0], f[3:0])}, {31'h0, cond_true});
        @(posedge hclk);
      end
    end
    bus(1'b0, adr(IDX_FLAGS), 32'h0);
    check("flags core", 32'hFC, rd);
    // software flag write steers the test
    bus(1'b1, adr(IDX_FLAGS), 32'h40);
    cond_code <= 4'h6;
    @(posedge hclk);
    @(posedge hclk);
    check("cond sw zero", 32'h1, {31'h0, cond_true});
    // second reset in mid-run clears timer mode
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("timer_mode rst2", 32'h0, {24'h0, timer_mode});
    bus(1'b0, adr(IDX_TIMER_MODE), 32'h0);
    check("timer_mode rd2", 32'h0, rd);
    print_verdict();
  end
endmodule

`default_nettype wire
